// ==== hw/pts_top.sv ====
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module pts_top
#(
    parameter logic [31:0] MS_CYCLES = pts_pkg::MS_CYCLES
)
(
    // Clock and reset
    input  wire logic                 mclk_in,
    input  wire logic                 rst_in,
    // Register port
    input  wire pts_pkg::pts_bus_t    bus_in,
    output logic [31:0]               rd_data_out,
    // Source signals, index 0 never read
    input  wire logic [7:0][31:0]     sig_in,
    // Selector result
    output logic [31:0]               result_out,
    output logic [31:0]               result_min_out,
    output logic [31:0]               result_max_out,
    output logic [1:0]                slot_out
);

    typedef struct packed {
        pts_pkg::pts_state_t           st;
        logic [1:0]                    t;
        logic [3:0]                    i;
        logic                          stop;
        logic                          found;
        logic                          ramp;
        logic                          dstart;
        logic [3:0]                    seg;
        logic [31:0]                   ax;
        logic [31:0]                   lo;
        logic [31:0]                   hi;
        logic [31:0]                   res;
        logic                          en;
        pts_pkg::pts_tcfg_t [2:0]      tcfg;
        pts_pkg::pts_slot_t [2:0]      slot;
        logic [2:0][10:0][31:0]        x;
        logic [2:0][10:0][31:0]        y;
        logic [2:0][10:0][1:0]         shp;
        logic [2:0][31:0]              tout;
        logic [2:0][31:0]              tmin;
        logic [2:0][31:0]              tmax;
        logic [2:0][31:0]              msc;
        logic [31:0]                   pre;
        logic [31:0]                   out;
        logic [31:0]                   omin;
        logic [31:0]                   omax;
        logic [31:0]                   rd;
        logic [1:0]                    sel;
    } pts_regs_t;

    pts_regs_t         s;
    pts_regs_t         n;
    logic signed [32:0] dx;
    logic signed [32:0] dy;
    logic signed [65:0] prod;
    logic [31:0]       den;
    logic              q_done;
    logic [31:0]       q_quo;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] src_val(input logic [2:0] sel,
                                            input logic [7:0][31:0] sig);
        src_val = (sel == 3'h0) ? 32'h0 : sig[sel];
    endfunction

    function automatic logic cmp(input logic [2:0] op, input logic [31:0] a,
                                 input logic [31:0] b);
        case (op)
            pts_pkg::OP_EQ: cmp = (a == b);
            pts_pkg::OP_NE: cmp = (a != b);
            pts_pkg::OP_GT: cmp = ($signed(a) > $signed(b));
            pts_pkg::OP_GE: cmp = ($signed(a) >= $signed(b));
            pts_pkg::OP_LT: cmp = ($signed(a) < $signed(b));
            pts_pkg::OP_LE: cmp = ($signed(a) <= $signed(b));
            default:        cmp = 1'b0;
        endcase
    endfunction

    function automatic logic slot_hit(input pts_pkg::pts_slot_t sl,
                                      input logic [7:0][31:0] sig);
        logic [2:0] c;
        c = '0;
        for (int k = 0; k < 3; k++)
            c[k] = cmp(sl.cnd[k].op, src_val(sl.cnd[k].a1, sig),
                       src_val(sl.cnd[k].a2, sig));
        case (sl.cmb)
            pts_pkg::CMB_DEFAULT: slot_hit = 1'b1;
            pts_pkg::CMB_ALL:     slot_hit = &c;
            pts_pkg::CMB_ANY:     slot_hit = |c;
            pts_pkg::CMB_AB_OR_C: slot_hit = (c[0] & c[1]) | c[2];
            pts_pkg::CMB_A_OR_BC: slot_hit = (c[0] | c[1]) & c[2];
            default:              slot_hit = 1'b0;
        endcase
    endfunction

    // Table number 1..3; zero falls back to table 1
    function automatic logic [1:0] tab_idx(input logic [1:0] no);
        tab_idx = (no == 2'h0) ? 2'h0 : no - 2'h1;
    endfunction

    function automatic logic [31:0] clampx(input logic [31:0] v,
                                           input logic [31:0] lo,
                                           input logic [31:0] hi);
        if ($signed(v) < $signed(lo))
            clampx = lo;
        else if ($signed(v) > $signed(hi))
            clampx = hi;
        else
            clampx = v;
    endfunction

    // ------------------------------------------------------------
    // Ramp arithmetic, stable while the divider runs
    // ------------------------------------------------------------
    assign dx   = $signed({s.ax[31], s.ax})
                - $signed({s.x[s.t][s.seg - 4'h1][31], s.x[s.t][s.seg - 4'h1]});
    assign dy   = $signed({s.y[s.t][s.seg][31], s.y[s.t][s.seg]})
                - $signed({s.y[s.t][s.seg - 4'h1][31], s.y[s.t][s.seg - 4'h1]});
    assign prod = dx * dy;
    assign den  = s.x[s.t][s.seg] - s.x[s.t][s.seg - 4'h1];

    pts_div u_div
    (
        .mclk_in  (mclk_in),
        .rst_in   (rst_in),
        .start_in (s.dstart),
        .num_in   (prod[63:0]),
        .den_in   (den),
        .done_out (q_done),
        .quo_out  (q_quo)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic        tick;
        logic [1:0]  ti;
        logic [1:0]  at;
        logic [3:0]  ap;
        logic [3:0]  pdn;
        logic [3:0]  pup;
        logic [31:0] yi;
        tick = 1'b0;
        ti = '0;
        at = bus_in.addr[5:4];
        ap = bus_in.addr[3:0];
        pdn = (ap == 4'h0) ? ap : ap - 4'h1;
        pup = (ap == pts_pkg::LAST_PT) ? ap : ap + 4'h1;
        yi = s.y[s.t][s.i];
        n = s;
        n.dstart = 1'b0;
        n.rd = '0;

        // Millisecond base, one tick per period
        tick = (s.pre == MS_CYCLES - 32'h1);
        n.pre = tick ? 32'h0 : s.pre + 32'h1;
        for (int k = 0; k < pts_pkg::NTAB; k++)
        begin
            if (src_val(s.tcfg[k].src, sig_in) == 32'h0)
                n.msc[k] = 32'h0;
            else if (tick && s.msc[k] != 32'hffffffff)
                n.msc[k] = s.msc[k] + 32'h1;
        end

        // Table walk: one table per pass, then the selector
        case (s.st)
            pts_pkg::ST_LOAD:
            begin
                n.ax = s.tcfg[s.t].kind ? s.msc[s.t]
                                        : src_val(s.tcfg[s.t].src, sig_in);
                n.lo = s.y[s.t][0];
                n.hi = s.y[s.t][0];
                n.res = s.y[s.t][0];
                n.i = 4'h1;
                n.stop = 1'b0;
                n.ramp = 1'b0;
                n.seg = 4'h0;
                // Point zero is a jump: everything at or below x0 gives y0
                n.found = ($signed(n.ax) <= $signed(s.x[s.t][0]));
                n.st = pts_pkg::ST_SCAN;
            end
            pts_pkg::ST_SCAN:
            begin
                if (!s.stop && s.shp[s.t][s.i] != pts_pkg::SHP_IGNORE)
                begin
                    if ($signed(yi) < $signed(s.lo))
                        n.lo = yi;
                    if ($signed(yi) > $signed(s.hi))
                        n.hi = yi;
                    // Above the last active point the last y holds
                    if (!s.found)
                    begin
                        n.res = yi;
                        if ($signed(s.ax) <= $signed(s.x[s.t][s.i]))
                        begin
                            n.found = 1'b1;
                            n.seg = s.i;
                            n.ramp = (s.shp[s.t][s.i] == pts_pkg::SHP_RAMP);
                        end
                    end
                end
                else
                    n.stop = 1'b1;
                if (s.i == pts_pkg::LAST_PT)
                begin
                    n.dstart = n.ramp;
                    n.st = n.ramp ? pts_pkg::ST_DIV : pts_pkg::ST_STORE;
                end
                else
                    n.i = s.i + 4'h1;
            end
            pts_pkg::ST_DIV:
            begin
                if (q_done)
                begin
                    n.res = s.y[s.t][s.seg - 4'h1] + q_quo;
                    n.st = pts_pkg::ST_STORE;
                end
            end
            pts_pkg::ST_STORE:
            begin
                n.tout[s.t] = s.res;
                n.tmin[s.t] = s.lo;
                n.tmax[s.t] = s.hi;
                n.t = (s.t == 2'h2) ? 2'h0 : s.t + 2'h1;
                n.st = (s.t == 2'h2) ? pts_pkg::ST_SEL : pts_pkg::ST_LOAD;
            end
            pts_pkg::ST_SEL:
            begin
                ti = tab_idx(s.slot[0].tab);
                n.sel = 2'h0;
                // Walk down so the lowest satisfied slot wins
                for (int k = 2; k >= 0; k--)
                begin
                    if (slot_hit(s.slot[k], sig_in))
                    begin
                        ti = tab_idx(s.slot[k].tab);
                        n.sel = 2'(k);
                    end
                end
                n.out = s.en ? s.tout[ti] : 32'h0;
                n.omin = s.en ? s.tmin[ti] : 32'h0;
                n.omax = s.en ? s.tmax[ti] : 32'h0;
                n.st = pts_pkg::ST_LOAD;
            end
            default:
                n.st = pts_pkg::ST_LOAD;
        endcase

        // Register writes
        if (bus_in.wr)
        begin
            if (bus_in.addr == pts_pkg::A_CTRL)
                n.en = bus_in.wdata[pts_pkg::CTRL_EN_BIT];
            else if (bus_in.addr[7:2] == pts_pkg::A_TCFG[7:2] && ap[1:0] != 2'h3)
            begin
                n.tcfg[ap[1:0]].kind = bus_in.wdata[pts_pkg::TCFG_KIND_BIT];
                n.tcfg[ap[1:0]].src = bus_in.wdata[pts_pkg::TCFG_SRC_LSB +: 3];
            end
            else if (bus_in.addr[7:2] == pts_pkg::A_SLOT[7:2] && ap[1:0] != 2'h3)
            begin
                n.slot[ap[1:0]].tab = bus_in.wdata[pts_pkg::SLOT_TAB_LSB +: 2];
                n.slot[ap[1:0]].cmb = bus_in.wdata[pts_pkg::SLOT_CMB_LSB +: 3];
            end
            else if (bus_in.addr[7:4] == pts_pkg::A_COND[7:4] && ap[3:2] != 2'h3
                     && ap[1:0] != 2'h3)
            begin
                n.slot[ap[3:2]].cnd[ap[1:0]].op = bus_in.wdata[pts_pkg::COND_OP_LSB +: 3];
                n.slot[ap[3:2]].cnd[ap[1:0]].a1 = bus_in.wdata[pts_pkg::COND_A1_LSB +: 3];
                n.slot[ap[3:2]].cnd[ap[1:0]].a2 = bus_in.wdata[pts_pkg::COND_A2_LSB +: 3];
            end
            else if (at != 2'h3 && ap <= pts_pkg::LAST_PT)
            begin
                case (bus_in.addr[7:6])
                    pts_pkg::R_X:
                        // Neighbours bound each x; write x10 first, then downward
                        n.x[at][ap] = clampx(bus_in.wdata,
                            (ap == 4'h0) ? pts_pkg::X_MIN : s.x[at][pdn],
                            (ap == pts_pkg::LAST_PT) ? pts_pkg::X_MAX
                                                     : s.x[at][pup]);
                    pts_pkg::R_Y:
                        n.y[at][ap] = bus_in.wdata;
                    pts_pkg::R_SHP:
                        if (ap != 4'h0)
                            n.shp[at][ap] = bus_in.wdata[1:0];
                    default:
                        n.en = s.en;
                endcase
            end
        end

        // Register reads, data in the following cycle only
        if (bus_in.rd)
        begin
            if (bus_in.addr == pts_pkg::A_CTRL)
                n.rd[pts_pkg::CTRL_EN_BIT] = s.en;
            else if (bus_in.addr == pts_pkg::A_OUT)
                n.rd = s.out;
            else if (bus_in.addr == pts_pkg::A_STAT)
                n.rd = {24'h0, 2'h0, s.sel, 1'b0, s.st};
            else if (bus_in.addr[7:2] == pts_pkg::A_TCFG[7:2] && ap[1:0] != 2'h3)
            begin
                n.rd[pts_pkg::TCFG_KIND_BIT] = s.tcfg[ap[1:0]].kind;
                n.rd[pts_pkg::TCFG_SRC_LSB +: 3] = s.tcfg[ap[1:0]].src;
            end
            else if (bus_in.addr[7:2] == pts_pkg::A_SLOT[7:2] && ap[1:0] != 2'h3)
            begin
                n.rd[pts_pkg::SLOT_TAB_LSB +: 2] = s.slot[ap[1:0]].tab;
                n.rd[pts_pkg::SLOT_CMB_LSB +: 3] = s.slot[ap[1:0]].cmb;
            end
            else if (bus_in.addr[7:4] == pts_pkg::A_COND[7:4] && ap[3:2] != 2'h3
                     && ap[1:0] != 2'h3)
            begin
                n.rd[pts_pkg::COND_OP_LSB +: 3] = s.slot[ap[3:2]].cnd[ap[1:0]].op;
                n.rd[pts_pkg::COND_A1_LSB +: 3] = s.slot[ap[3:2]].cnd[ap[1:0]].a1;
                n.rd[pts_pkg::COND_A2_LSB +: 3] = s.slot[ap[3:2]].cnd[ap[1:0]].a2;
            end
            else if (bus_in.addr[7:4] == pts_pkg::A_TRES[7:4] && ap[1:0] != 2'h3)
            begin
                case (ap[3:2])
                    2'h0:    n.rd = s.tout[ap[1:0]];
                    2'h1:    n.rd = s.tmin[ap[1:0]];
                    2'h2:    n.rd = s.tmax[ap[1:0]];
                    default: n.rd = 32'h0;
                endcase
            end
            else if (at != 2'h3 && ap <= pts_pkg::LAST_PT)
            begin
                case (bus_in.addr[7:6])
                    pts_pkg::R_X:   n.rd = s.x[at][ap];
                    pts_pkg::R_Y:   n.rd = s.y[at][ap];
                    pts_pkg::R_SHP: n.rd[1:0] = (ap == 4'h0) ? pts_pkg::SHP_JUMP
                                                             : s.shp[at][ap];
                    default:        n.rd = 32'h0;
                endcase
            end
        end
    end

    // Reset leaves every table flat at zero and the selector disabled
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            s <= '0;
        else
            s <= n;
    end

    assign rd_data_out    = s.rd;
    assign result_out     = s.out;
    assign result_min_out = s.omin;
    assign result_max_out = s.omax;
    assign slot_out       = s.sel;

endmodule

// ==== include/pts_pkg.sv ====
package pts_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int          NTAB    = 3;
    localparam int          NPT     = 11;
    localparam logic [3:0]  LAST_PT = 4'ha;

    // ------------------------------------------------------------
    // Codes
    // ------------------------------------------------------------
    localparam logic [1:0] SHP_IGNORE = 2'h0;
    localparam logic [1:0] SHP_RAMP   = 2'h1;
    localparam logic [1:0] SHP_JUMP   = 2'h2;

    localparam logic [2:0] OP_EQ = 3'h0;
    localparam logic [2:0] OP_NE = 3'h1;
    localparam logic [2:0] OP_GT = 3'h2;
    localparam logic [2:0] OP_GE = 3'h3;
    localparam logic [2:0] OP_LT = 3'h4;
    localparam logic [2:0] OP_LE = 3'h5;

    localparam logic [2:0] CMB_DEFAULT = 3'h0;
    localparam logic [2:0] CMB_ALL     = 3'h1;
    localparam logic [2:0] CMB_ANY     = 3'h2;
    localparam logic [2:0] CMB_AB_OR_C = 3'h3;
    localparam logic [2:0] CMB_A_OR_BC = 3'h4;

    localparam logic [31:0] X_MIN = 32'hfffe7960;
    localparam logic [31:0] X_MAX = 32'h000f4240;

    // ------------------------------------------------------------
    // Register map, word addresses
    // ------------------------------------------------------------
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_OUT  = 8'h01;
    localparam logic [7:0] A_STAT = 8'h02;
    localparam logic [7:0] A_TCFG = 8'h04;
    localparam logic [7:0] A_SLOT = 8'h08;
    localparam logic [7:0] A_COND = 8'h10;
    localparam logic [7:0] A_TRES = 8'h20;
    localparam logic [1:0] R_X    = 2'h1;
    localparam logic [1:0] R_Y    = 2'h2;
    localparam logic [1:0] R_SHP  = 2'h3;

    localparam int CTRL_EN_BIT  = 0;
    localparam int TCFG_KIND_BIT = 0;
    localparam int TCFG_SRC_LSB = 4;
    localparam int SLOT_TAB_LSB = 0;
    localparam int SLOT_CMB_LSB = 4;
    localparam int COND_OP_LSB  = 0;
    localparam int COND_A1_LSB  = 4;
    localparam int COND_A2_LSB  = 8;
    localparam int STAT_SEL_LSB = 4;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int          MS_NS     = 1000000;
    localparam int          CLK_NS    = 25;
    localparam logic [31:0] MS_CYCLES = 32'(MS_NS / CLK_NS);
    localparam logic [6:0]  DIV_STEPS = 7'h40;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } pts_bus_t;

    typedef struct packed {
        logic       kind;
        logic [2:0] src;
    } pts_tcfg_t;

    typedef struct packed {
        logic [2:0] op;
        logic [2:0] a1;
        logic [2:0] a2;
    } pts_cond_t;

    typedef struct packed {
        logic [1:0]           tab;
        logic [2:0]           cmb;
        pts_cond_t [2:0]      cnd;
    } pts_slot_t;

    typedef enum logic [2:0] {
        ST_LOAD  = 3'b000,
        ST_SCAN  = 3'b001,
        ST_DIV   = 3'b010,
        ST_STORE = 3'b011,
        ST_SEL   = 3'b100
    } pts_state_t;

endpackage

// ==== hw/pts_div.sv ====
`timescale 1ns/1ps
module pts_div
(
    // Clock and reset
    input  wire logic        mclk_in,
    input  wire logic        rst_in,
    // Request
    input  wire logic        start_in,
    input  wire logic [63:0] num_in,
    input  wire logic [31:0] den_in,
    // Answer
    output logic             done_out,
    output logic [31:0]      quo_out
);

    typedef struct packed {
        logic        busy;
        logic        done;
        logic        neg;
        logic [6:0]  n;
        logic [31:0] den;
        logic [63:0] q;
        logic [32:0] r;
    } pts_div_regs_t;

    pts_div_regs_t s;
    pts_div_regs_t n;

    // ------------------------------------------------------------
    // Restoring divide on magnitudes, truncates toward zero
    // ------------------------------------------------------------
    always_comb
    begin
        logic [32:0] rem;
        rem = '0;
        n = s;
        n.done = 1'b0;
        if (start_in)
        begin
            n.busy = 1'b1;
            n.neg = num_in[63];
            n.q = num_in[63] ? 64'h0 - num_in : num_in;
            n.r = '0;
            n.den = den_in;
            n.n = pts_pkg::DIV_STEPS;
        end
        else if (s.busy)
        begin
            rem = {s.r[31:0], s.q[63]};
            n.q = {s.q[62:0], 1'b0};
            if (rem >= {1'b0, s.den})
            begin
                rem = rem - {1'b0, s.den};
                n.q[0] = 1'b1;
            end
            n.r = rem;
            n.n = s.n - 7'h1;
            if (s.n == 7'h1)
            begin
                n.busy = 1'b0;
                n.done = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            s <= '0;
        else
            s <= n;
    end

    assign done_out = s.done;
    assign quo_out  = s.neg ? 32'h0 - s.q[31:0] : s.q[31:0];

endmodule

// ==== tb/pts_top_asserts.sv ====
`timescale 1ns/1ps
module pts_top_asserts
#(
    parameter logic [31:0] MS_CYCLES = 32'h4
)
(
    // Clock, reset and register port
    input  wire logic              mclk_in,
    input  wire logic              rst_in,
    input  wire pts_pkg::pts_bus_t bus_in,
    input  wire logic [31:0]       rd_data_out,
    // Selector result
    input  wire logic [31:0]       result_out,
    input  wire logic [31:0]       result_min_out,
    input  wire logic [31:0]       result_max_out,
    input  wire logic [1:0]        slot_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    logic en;
    // Shadow of the enable bit, so readback can be judged without the body
    always_ff @(posedge mclk_in or posedge rst_in)
        if (rst_in)
            en <= 1'b0;
        else if (bus_in.wr && bus_in.addr == pts_pkg::A_CTRL)
            en <= bus_in.wdata[0];
    property p_rst_off; $fell(rst_in) |-> (result_out == 32'h0) [*8]; endproperty
    a_rst_off: assert property (p_rst_off) else $error("result not zero after reset");
    property p_ctrl; bus_in.rd && bus_in.addr == pts_pkg::A_CTRL |=> rd_data_out == {31'h0, en};
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("enable readback wrong");
    property p_shp0; bus_in.rd && bus_in.addr[7:6] == 2'h3 && bus_in.addr[5:4] != 2'h3
        && bus_in.addr[3:0] == 4'h0 |=> rd_data_out == 32'h2; endproperty
    a_shp0: assert property (p_shp0) else $error("first point shape not jump");
    property p_x_rng; $past(bus_in.rd) && $past(bus_in.addr[7:6]) == 2'h1 |->
        $signed(rd_data_out) >= $signed(pts_pkg::X_MIN)
        && $signed(rd_data_out) <= $signed(pts_pkg::X_MAX); endproperty
    a_x_rng: assert property (p_x_rng) else $error("breakpoint out of range");
    property p_slot3; bus_in.rd && bus_in.addr == 8'h0b |=> rd_data_out == 32'h0; endproperty
    a_slot3: assert property (p_slot3) else $error("fourth slot readable");
    property p_minmax; $signed(result_min_out) <= $signed(result_max_out); endproperty
    a_minmax: assert property (p_minmax) else $error("min above max");
    property p_in_rng; $signed(result_out) >= $signed(result_min_out)
        && $signed(result_out) <= $signed(result_max_out); endproperty
    a_in_rng: assert property (p_in_rng) else $error("result outside min and max");
    property p_slot_ok; slot_out != 2'h3; endproperty
    a_slot_ok: assert property (p_slot_ok) else $error("slot index beyond three");
    c_slot1: cover property (slot_out == 2'h1);
    c_top: cover property (result_out == 32'd500);
    c_shp0: cover property (bus_in.rd && bus_in.addr == 8'hc0);
endmodule
bind pts_top pts_top_asserts #(.MS_CYCLES(MS_CYCLES)) i_pts_top_asserts (.mclk_in(mclk_in),
    .rst_in(rst_in), .bus_in(bus_in), .rd_data_out(rd_data_out), .result_out(result_out),
    .result_min_out(result_min_out), .result_max_out(result_max_out), .slot_out(slot_out));

// ==== tb/pts_src_model.sv ====
`timescale 1ns/1ps
module pts_src_model
(
    // Clock and values for sources 1..7
    input  wire logic             mclk_in,
    input  wire logic [7:1][31:0] val_in,
    // Sources toward the selector
    output logic [7:0][31:0]      sig_out
);
    logic [31:0] churn = 32'h0;
    // No-control source churns, so nothing can lean on a stale value
    always_ff @(posedge mclk_in)
        churn <= ~churn;
    assign sig_out = {val_in, churn};
endmodule

// ==== tb/tb_pts_top.sv ====
`timescale 1ns/1ps
module tb_pts_top;
    logic              mclk_in = 1'b0;
    logic              rst_in, smp, rd_d, c1;
    pts_pkg::pts_bus_t bus_in;
    logic [31:0]       rd_data_out, result_out, result_min_out, result_max_out, rnd;
    logic [1:0]        slot_out;
    logic [7:1][31:0]  val;
    logic [7:0][31:0]  sig_in;
    logic [97:0]       nq[$];
    logic [31:0]       rq[$];
    int                failures, num_checks, cycles;
    int                xa[5] = '{-50, 50, 100, 150, 5000};
    int                ya[5] = '{10, 60, 110, 500, 500};
    pts_top #(.MS_CYCLES(32'h4)) i_pts_top (.mclk_in(mclk_in), .rst_in(rst_in), .bus_in(bus_in),
        .rd_data_out(rd_data_out), .sig_in(sig_in), .result_out(result_out),
        .result_min_out(result_min_out), .result_max_out(result_max_out), .slot_out(slot_out));
    pts_src_model i_pts_src_model (.mclk_in(mclk_in), .val_in(val), .sig_out(sig_in));
    initial forever #12.5 mclk_in = ~mclk_in;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic chk_rd(input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        failures += (g !== e);
        if (g !== e) $display("[ERR] rd_data_out exp %h got %h", e, g);
    endtask
    task automatic chk_res(input logic [97:0] e, input logic [97:0] g);
        num_checks++;
        failures += (g !== e);
        if (g !== e) $display("[ERR] result exp %h got %h", e, g);
    endtask
    task automatic print_verdict();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge mclk_in)
    begin
        rd_d <= bus_in.rd;
        cycles++;
        if (cycles == 50000)
        begin
            failures++;
            print_verdict();
        end
    end
    // Read data stand for one cycle only, so look mid-cycle
    always @(negedge mclk_in)
    begin
        if (rd_d) chk_rd(rq.pop_front(), rd_data_out);
        if (smp) chk_res(nq.pop_front(), {result_out, result_min_out, result_max_out, slot_out});
    end
    // ------------------------------------------------------------
    // Driver
    // ------------------------------------------------------------
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        if (!w) rq.push_back(d);
        bus_in <= '{a, d, w, !w};
        @(posedge mclk_in);
        bus_in <= '0;
        @(posedge mclk_in);
    endtask
    // Loop may need up to ~250 cycles to reflect a change
    task automatic res(input logic [31:0] r, mn, mx, input logic [1:0] s);
        repeat (300) @(posedge mclk_in);
        nq.push_back({r, mn, mx, s});
        smp <= 1'b1;
        @(posedge mclk_in);
        smp <= 1'b0;
    endtask
    initial
    begin
        bus_in = '0;
        val = '0;
        smp = 1'b0;
        rnd = 32'h535e;
        rst_in = 1'b1;
        repeat (16) @(posedge mclk_in);
        rst_in <= 1'b0;
        acc(0, pts_pkg::A_CTRL, 32'h0);
        acc(0, 8'hc0, 32'h2);
        acc(1, 8'hc0, 32'h1);
        acc(0, 8'hc0, 32'h2);
        acc(0, 8'h0b, 32'h0);
        acc(1, 8'h4a, 32'd2000000);
        acc(0, 8'h4a, pts_pkg::X_MAX);
        acc(1, 8'h49, 32'hfffc0000);
        acc(0, 8'h49, 32'h0);
        $display("test registers done");
        for (int i = 10; i >= 0; i--) acc(1, 8'h40 + 8'(i), 32'(100 * i));
        acc(1, 8'h80, 32'd10);
        acc(1, 8'h81, 32'd110);
        acc(1, 8'h82, 32'd500);
        acc(1, 8'h83, 32'hffffff00);
        acc(1, 8'h84, 32'd9999);
        acc(1, 8'hc1, 32'(pts_pkg::SHP_RAMP));
        acc(1, 8'hc2, 32'(pts_pkg::SHP_JUMP));
        acc(1, 8'hc4, 32'(pts_pkg::SHP_RAMP));
        acc(1, 8'h04, 32'h10);
        acc(1, pts_pkg::A_CTRL, 32'h1);
        foreach (xa[i])
        begin
            val[1] <= 32'(xa[i]);
            res(32'(ya[i]), 32'd10, 32'd500, 2'h0);
        end
        repeat (4)
        begin
            rnd = xs(rnd);
            val[1] <= rnd % 100;
            res(32'd10 + rnd % 100, 32'd10, 32'd500, 2'h0);
        end
        $display("test table done");
        acc(1, 8'h04, 32'h21);
        res(32'd10, 32'd10, 32'd500, 2'h0);
        val[2] <= 32'h1;
        repeat (6000) @(posedge mclk_in);
        res(32'd500, 32'd10, 32'd500, 2'h0);
        val[2] <= 32'h0;
        res(32'd10, 32'd10, 32'd500, 2'h0);
        $display("test time done");
        acc(1, 8'h04, 32'h10);
        val[1] <= 32'd150;
        val[4] <= 32'd3;
        acc(1, 8'h11, 32'h1);
        acc(1, 8'h09, 32'h2);
        for (int op = 0; op < 6; op++)
            for (int a = 3; a < 6; a += 2)
                for (int cb = 0; cb < 5; cb++)
                begin
                    c1 = a == 3 ? (op == 0 || op == 3 || op == 5) : (op > 0 && op < 4);
                    acc(1, 8'h10, 32'h430 | 32'(op));
                    acc(1, 8'h08, 32'h1 | 32'(cb << 4));
                    val[3] <= 32'(a);
                    if (cb == 0 || cb == 2 || cb == 3 || (cb == 4 && c1))
                        res(32'd500, 32'd10, 32'd500, 2'h0);
                    else
                        res(32'h0, 32'h0, 32'h0, 2'h1);
                end
        acc(1, 8'h15, 32'h1);
        acc(1, 8'h09, 32'h12);
        acc(1, 8'h19, 32'h1);
        acc(1, 8'h0a, 32'h10);
        acc(1, 8'h08, 32'h11);
        res(32'd500, 32'd10, 32'd500, 2'h0);
        acc(0, pts_pkg::A_OUT, 32'd500);
        $display("test selector done");
        print_verdict();
    end
endmodule
